/* File: shared/bulk_write_defines.svh */
// Register offsets, field positions, reset values and parse constants of the bulk write handler
`ifndef BULK_WRITE_DEFINES_SVH
`define BULK_WRITE_DEFINES_SVH

`define BW_REG_CTRL      8'h00
`define BW_REG_STATUS    8'h04
`define BW_REG_NAME      8'h08
`define BW_REG_SIG_SEL   8'h0c
`define BW_REG_SIG_DATA  8'h10

`define BW_CTRL_MULTI    0
`define BW_CTRL_CLR      1
`define BW_CTRL_CHAN_LSB 8
`define BW_CTRL_RST      32'h0000_0000

`define BW_STAT_BUSY     0
`define BW_STAT_ERR      1
`define BW_STAT_CNT_LSB  16

`define BW_RESP_OKAY     2'h0
`define BW_RESP_DECERR   2'h3

`define BW_MAX_VALUES    16'h0190

`define BW_MODE_VALUES   2'h0
`define BW_MODE_STRING   2'h1
`define BW_MODE_REPEAT   2'h2

`define BW_P_CHAN        3'h0
`define BW_P_MODE        3'h1
`define BW_P_START       3'h2
`define BW_P_DATA        3'h3
`define BW_P_VALUE       3'h4

`define BW_CH_SPACE      8'h20
`define BW_CH_CR         8'h0d
`define BW_CH_LF         8'h0a
`define BW_CH_BANG       8'h21
`define BW_CH_BSL        8'h5c

`endif

/* File: shared/bw_pkg.sv */
// Types shared by the bulk signal write handler
package bw_pkg;

   typedef enum logic [3:0] {
      ST_SKIP, ST_NUM, ST_NAME, ST_STR, ST_ESC_HI, ST_ESC_LO, ST_LOOKUP, ST_FILL, ST_DROP
   } parse_state_t;

   typedef struct packed {
      logic        valid;
      logic [7:0]  chan;
      logic [15:0] index;
      logic [31:0] value;
   } sig_wr_t;

   typedef struct packed {
      logic        valid;
      logic        err;
      logic [15:0] count;
   } cmd_done_t;

endpackage

/* File: logic/signal_store.sv */
// Signal value memory with one write port and a registered read port
`timescale 1ns/10ps
module signal_store #(
   parameter int NSIG  = 512,
   parameter int SIG_W = 8
) (
   input  wire logic                    mclk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    wr_en_i,
   input  wire logic [$clog2(NSIG)-1:0] wr_addr_i,
   input  wire logic [SIG_W-1:0]        wr_data_i,
   input  wire logic [$clog2(NSIG)-1:0] rd_addr_i,
   output logic      [SIG_W-1:0]        rd_data_o
);

   typedef struct packed {
      logic [NSIG-1:0][SIG_W-1:0] mem;
      logic [SIG_W-1:0]           rd;
   } store_t;

   store_t s;
   store_t next_s;

   always_comb begin
      next_s = s;
      if (wr_en_i) begin
         next_s.mem[wr_addr_i] = wr_data_i;
      end
      next_s.rd = s.mem[rd_addr_i];
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rd_data_o = s.rd;

endmodule

/* File: logic/name_table.sv */
// Table that resolves a hashed signal name to its signal index
`timescale 1ns/10ps
module name_table #(
   parameter int NAMES = 16
) (
   input  wire logic        mclk_i,
   input  wire logic        sys_rst_i,
   input  wire logic        clr_i,
   input  wire logic        wr_en_i,
   input  wire logic [15:0] wr_hash_i,
   input  wire logic [15:0] wr_idx_i,
   input  wire logic [15:0] key_i,
   output logic             hit_o,
   output logic      [15:0] idx_o
);

   typedef struct packed {
      logic [NAMES-1:0]       used;
      logic [NAMES-1:0][15:0] hash;
      logic [NAMES-1:0][15:0] idx;
      logic                   hit;
      logic [15:0]            res;
   } table_t;

   table_t           s;
   table_t           next_s;
   logic [NAMES-1:0] match;
   logic [NAMES-1:0] first_free;

   for (genvar e = 0; e < NAMES; e++) begin : g_match
      assign match[e] = s.used[e] && (s.hash[e] == key_i);
      // Only the lowest unused entry is offered to an append
      if (e == 0) begin : g_first
         assign first_free[e] = !s.used[0];
      end else begin : g_rest
         assign first_free[e] = !s.used[e] && (&s.used[e-1:0]);
      end
   end

   always_comb begin
      next_s = s;
      next_s.hit = |match;
      next_s.res = '0;
      // Lowest entry wins when software loaded the same hash twice
      for (int e = NAMES - 1; e >= 0; e--) begin
         if (match[e]) begin
            next_s.res = s.idx[e];
         end
      end
      if (clr_i) begin
         next_s.used = '0;
      end else if (wr_en_i) begin
         // A full table ignores further entries
         for (int e = NAMES - 1; e >= 0; e--) begin
            if (first_free[e]) begin
               next_s.used[e] = 1'b1;
               next_s.hash[e] = wr_hash_i;
               next_s.idx[e]  = wr_idx_i;
            end
         end
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign hit_o = s.hit;
   assign idx_o = s.res;

endmodule

/* File: logic/bulk_signal_write.sv */
// Bulk signal write command interpreter with an AXI4-Lite register slave
//
// Notes on behaviour
// - A command writes the start signal and then each following signal in turn.
// - With one connection per channel the channel parameter is absent and parsing skips it.
// - The mode parameter picks 0 individual values, 1 a string, 2 one repeated value.
// - In mode 0 each given value goes to the next target signal in order.
// - Modes 0 and 1 accept at most 400 values per command.
// - In mode 1 each character code of the string goes to the next target signal.
// - A backslash and two hex digits in a string stand for one character code.
// - So a carriage return arrives as backslash 0D and becomes one signal value.
// - In mode 2 the single value goes to every signal of the range.
// - A value wider than the signal is cut to fit, never refused.
// - A signal is given by number or by a name led by an exclamation mark.
`timescale 1ns/10ps
`include "bulk_write_defines.svh"
module bulk_signal_write #(
   parameter int NSIG  = 512,
   parameter int SIG_W = 8,
   parameter int NAMES = 16
) (
   input  wire logic             mclk_i,
   input  wire logic             sys_rst_i,
   input  wire logic [7:0]       s_axi_awaddr_i,
   input  wire logic             s_axi_awvalid_i,
   output logic                  s_axi_awready_o,
   input  wire logic [31:0]      s_axi_wdata_i,
   input  wire logic [3:0]       s_axi_wstrb_i,
   input  wire logic             s_axi_wvalid_i,
   output logic                  s_axi_wready_o,
   output logic      [1:0]       s_axi_bresp_o,
   output logic                  s_axi_bvalid_o,
   input  wire logic             s_axi_bready_i,
   input  wire logic [7:0]       s_axi_araddr_i,
   input  wire logic             s_axi_arvalid_i,
   output logic                  s_axi_arready_o,
   output logic      [31:0]      s_axi_rdata_o,
   output logic      [1:0]       s_axi_rresp_o,
   output logic                  s_axi_rvalid_o,
   input  wire logic             s_axi_rready_i,
   input  wire logic [7:0]       cmd_byte_i,
   input  wire logic             cmd_valid_i,
   output logic                  cmd_ready_o,
   output bw_pkg::sig_wr_t       sig_wr_o,
   output bw_pkg::cmd_done_t     cmd_done_o
);

   localparam int          IDX_W    = $clog2(NSIG);
   localparam logic [31:0] VAL_MASK = 32'hffff_ffff >> (32 - SIG_W);

   typedef struct packed {
      bw_pkg::parse_state_t st;
      logic [2:0]           pidx;
      logic                 lk;
      logic                 eol;
      logic                 err;
      logic [31:0]          acc;
      logic [15:0]          hash;
      logic [7:0]           chan;
      logic [1:0]           mode;
      logic [15:0]          cur;
      logic [15:0]          cnt;
      logic [15:0]          left;
      logic [31:0]          fill_val;
      logic [3:0]           esc_hi;
      bw_pkg::sig_wr_t      wr;
      bw_pkg::cmd_done_t    done;
      logic [31:0]          ctrl;
      logic                 last_err;
      logic [15:0]          last_cnt;
      logic [15:0]          sig_sel;
      logic                 nt_wr;
      logic                 nt_clr;
      logic [31:0]          nt_data;
      logic                 aw_got;
      logic                 w_got;
      logic [7:0]           awaddr;
      logic [31:0]          wdata;
      logic [3:0]           wstrb;
      logic                 bvalid;
      logic [1:0]           bresp;
      logic                 rvalid;
      logic [31:0]          rdata;
      logic [1:0]           rresp;
   } state_t;

   state_t             s;
   state_t             next_s;
   logic               fire;
   logic [2:0]         p;
   logic               c_dig;
   logic               c_term;
   logic               c_space;
   logic [4:0]         hx;
   logic               as_str;
   logic               tok;
   logic               fin;
   logic               do_wr;
   logic [31:0]        wr_val;
   logic               bad;
   logic               short_cmd;
   logic [7:0]         chan_now;
   logic               nt_hit;
   logic [15:0]        nt_idx;
   logic [SIG_W-1:0]   sel_data;

   // Hex digit decode: bit 4 flags a legal digit
   function automatic logic [4:0] hex_of(input logic [7:0] ch);
      logic [4:0] r;
      r = 5'h00;
      if (ch >= 8'h30 && ch <= 8'h39) begin
         r = {1'b1, ch[3:0]};
      end else if ((ch >= 8'h41 && ch <= 8'h46) || (ch >= 8'h61 && ch <= 8'h66)) begin
         r = {1'b1, ch[3:0] + 4'h9};
      end
      return r;
   endfunction

   assign cmd_ready_o = (s.st != bw_pkg::ST_LOOKUP) && (s.st != bw_pkg::ST_FILL);
   assign fire        = cmd_valid_i && cmd_ready_o;
   assign p           = s.pidx + {2'b00, s.ctrl[`BW_CTRL_MULTI]};
   assign c_dig       = (cmd_byte_i >= 8'h30) && (cmd_byte_i <= 8'h39);
   assign c_term      = (cmd_byte_i == `BW_CH_CR) || (cmd_byte_i == `BW_CH_LF);
   assign c_space     = (cmd_byte_i == `BW_CH_SPACE);
   assign hx          = hex_of(cmd_byte_i);
   assign chan_now    = s.ctrl[`BW_CTRL_MULTI] ? s.ctrl[`BW_CTRL_CHAN_LSB +: 8] : s.chan;
   // In string mode everything from the first non-space byte up to the line end is text
   assign as_str      = (s.st == bw_pkg::ST_STR) ||
                        (s.st == bw_pkg::ST_SKIP && p == `BW_P_DATA &&
                         s.mode == `BW_MODE_STRING && !c_space);

   always_comb begin
      next_s             = s;
      next_s.wr.valid    = 1'b0;
      next_s.done.valid  = 1'b0;
      next_s.nt_wr       = 1'b0;
      next_s.nt_clr      = 1'b0;
      tok                = 1'b0;
      fin                = 1'b0;
      do_wr              = 1'b0;
      wr_val             = s.acc;
      bad                = 1'b0;
      short_cmd          = 1'b0;

      if (fire) begin
         if (as_str) begin
            if (c_term) begin
               fin = 1'b1;
            end else if (cmd_byte_i == `BW_CH_BSL) begin
               next_s.st = bw_pkg::ST_ESC_HI;
            end else begin
               next_s.st = bw_pkg::ST_STR;
               do_wr     = 1'b1;
               wr_val    = {24'h0, cmd_byte_i};
            end
         end else begin
            unique case (s.st)
               bw_pkg::ST_SKIP: begin
                  if (c_term) begin
                     // A bare line end, such as LF after CR, is not a command
                     fin = (s.pidx != 3'h0);
                  end else if (cmd_byte_i == `BW_CH_BANG && p == `BW_P_START) begin
                     next_s.st   = bw_pkg::ST_NAME;
                     next_s.hash = 16'h0000;
                  end else if (c_dig) begin
                     next_s.st  = bw_pkg::ST_NUM;
                     next_s.acc = {28'h0, cmd_byte_i[3:0]};
                  end else if (!c_space) begin
                     next_s.err = 1'b1;
                     next_s.st  = bw_pkg::ST_DROP;
                  end
               end
               bw_pkg::ST_NUM: begin
                  if (c_dig) begin
                     // Wraps at 32 bits; only the low bits survive anyway
                     next_s.acc = s.acc * 32'd10 + {28'h0, cmd_byte_i[3:0]};
                  end else if (c_term || c_space) begin
                     tok = 1'b1;
                  end else begin
                     next_s.err = 1'b1;
                     next_s.st  = bw_pkg::ST_DROP;
                  end
               end
               bw_pkg::ST_NAME: begin
                  if (c_term || c_space) begin
                     next_s.st  = bw_pkg::ST_LOOKUP;
                     next_s.eol = c_term;
                     next_s.lk  = 1'b0;
                  end else begin
                     next_s.hash = {s.hash[14:0], s.hash[15]} ^ {8'h00, cmd_byte_i};
                  end
               end
               bw_pkg::ST_ESC_HI: begin
                  if (hx[4]) begin
                     next_s.esc_hi = hx[3:0];
                     next_s.st     = bw_pkg::ST_ESC_LO;
                  end else begin
                     next_s.err = 1'b1;
                     next_s.st  = bw_pkg::ST_DROP;
                     fin        = c_term;
                  end
               end
               bw_pkg::ST_ESC_LO: begin
                  if (hx[4]) begin
                     do_wr     = 1'b1;
                     wr_val    = {24'h0, s.esc_hi, hx[3:0]};
                     next_s.st = bw_pkg::ST_STR;
                  end else begin
                     next_s.err = 1'b1;
                     next_s.st  = bw_pkg::ST_DROP;
                     fin        = c_term;
                  end
               end
               bw_pkg::ST_DROP: begin
                  fin = c_term;
               end
               default: begin
               end
            endcase
         end
      end

      if (s.st == bw_pkg::ST_LOOKUP) begin
         // The table answers one cycle after the key is presented
         next_s.lk = 1'b1;
         if (s.lk) begin
            next_s.pidx = s.pidx + 3'h1;
            if (nt_hit) begin
               next_s.cur = nt_idx;
               next_s.st  = bw_pkg::ST_SKIP;
            end else begin
               next_s.err = 1'b1;
               next_s.st  = bw_pkg::ST_DROP;
            end
            fin = s.eol;
         end
      end

      if (s.st == bw_pkg::ST_FILL) begin
         if (s.left != 16'h0000) begin
            do_wr       = 1'b1;
            wr_val      = s.fill_val;
            next_s.left = s.left - 16'h0001;
         end else if (s.eol) begin
            fin = 1'b1;
         end else begin
            next_s.st = bw_pkg::ST_SKIP;
         end
      end

      if (tok) begin
         next_s.st   = bw_pkg::ST_SKIP;
         next_s.pidx = (s.pidx == 3'h7) ? s.pidx : s.pidx + 3'h1;
         if (p >= `BW_P_DATA && s.mode == `BW_MODE_VALUES) begin
            do_wr = 1'b1;
         end else begin
            case (p)
               `BW_P_CHAN:  next_s.chan = s.acc[7:0];
               `BW_P_MODE: begin
                  next_s.mode = s.acc[1:0];
                  next_s.err  = s.err | (s.acc > 32'd2);
               end
               `BW_P_START: next_s.cur = s.acc[15:0];
               `BW_P_DATA:  next_s.left = s.acc[15:0];
               `BW_P_VALUE: begin
                  next_s.fill_val = s.acc;
                  next_s.st       = bw_pkg::ST_FILL;
                  next_s.eol      = c_term;
               end
               default:     next_s.err = 1'b1;
            endcase
         end
         if (next_s.err) begin
            next_s.st = bw_pkg::ST_DROP;
         end
         fin = c_term && (next_s.st != bw_pkg::ST_FILL);
      end

      if (do_wr) begin
         bad = ((s.mode != `BW_MODE_REPEAT) && (s.cnt == `BW_MAX_VALUES)) ||
               (s.cur >= 16'(NSIG));
         if (bad) begin
            next_s.err = 1'b1;
            if (s.st == bw_pkg::ST_FILL) begin
               next_s.left = 16'h0000;
            end else begin
               next_s.st = bw_pkg::ST_DROP;
            end
         end else begin
            next_s.wr.valid = 1'b1;
            next_s.wr.chan  = chan_now;
            next_s.wr.index = s.cur;
            next_s.wr.value = wr_val & VAL_MASK;
            next_s.cur      = s.cur + 16'h0001;
            next_s.cnt      = s.cnt + 16'h0001;
         end
      end

      if (fin) begin
         short_cmd          = (s.mode == `BW_MODE_REPEAT) ?
                              (p <= `BW_P_VALUE && next_s.st != bw_pkg::ST_FILL) :
                              (p <= `BW_P_START && !as_str);
         next_s.done.valid  = 1'b1;
         next_s.done.err    = next_s.err | short_cmd;
         next_s.done.count  = next_s.cnt;
         next_s.last_err    = next_s.err | short_cmd;
         next_s.last_cnt    = next_s.cnt;
         next_s.st          = bw_pkg::ST_SKIP;
         next_s.pidx        = 3'h0;
         next_s.err         = 1'b0;
         next_s.cnt         = 16'h0000;
         next_s.mode        = `BW_MODE_VALUES;
         next_s.chan        = 8'h00;
         next_s.eol         = 1'b0;
      end

      // AXI4-Lite write: address and data taken in either order, response after both
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_s.aw_got = 1'b1;
         next_s.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_s.w_got = 1'b1;
         next_s.wdata = s_axi_wdata_i;
         next_s.wstrb = s_axi_wstrb_i;
      end
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_got && s.w_got) begin
         next_s.aw_got = 1'b0;
         next_s.w_got  = 1'b0;
         next_s.bvalid = 1'b1;
         next_s.bresp  = `BW_RESP_OKAY;
         case (s.awaddr)
            `BW_REG_CTRL: begin
               for (int b = 0; b < 4; b++) begin
                  if (s.wstrb[b]) begin
                     next_s.ctrl[8*b +: 8] = s.wdata[8*b +: 8];
                  end
               end
               next_s.nt_clr            = s.wstrb[0] && s.wdata[`BW_CTRL_CLR];
               next_s.ctrl[`BW_CTRL_CLR] = 1'b0;
            end
            `BW_REG_NAME: begin
               next_s.nt_wr   = 1'b1;
               next_s.nt_data = s.wdata;
            end
            `BW_REG_SIG_SEL: begin
               for (int b = 0; b < 2; b++) begin
                  if (s.wstrb[b]) begin
                     next_s.sig_sel[8*b +: 8] = s.wdata[8*b +: 8];
                  end
               end
            end
            `BW_REG_STATUS, `BW_REG_SIG_DATA: begin
            end
            default:       next_s.bresp = `BW_RESP_DECERR;
         endcase
      end

      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = `BW_RESP_OKAY;
         next_s.rdata  = 32'h0000_0000;
         case (s_axi_araddr_i)
            `BW_REG_CTRL:     next_s.rdata = s.ctrl;
            `BW_REG_STATUS: begin
               next_s.rdata[`BW_STAT_BUSY]          = (s.st != bw_pkg::ST_SKIP) ||
                                                      (s.pidx != 3'h0);
               next_s.rdata[`BW_STAT_ERR]           = s.last_err;
               next_s.rdata[`BW_STAT_CNT_LSB +: 16] = s.last_cnt;
            end
            `BW_REG_NAME:     next_s.rdata = 32'h0000_0000;
            `BW_REG_SIG_SEL:  next_s.rdata = {16'h0000, s.sig_sel};
            `BW_REG_SIG_DATA: next_s.rdata[SIG_W-1:0] = sel_data;
            default:          next_s.rresp = `BW_RESP_DECERR;
         endcase
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s      <= '0;
         s.ctrl <= `BW_CTRL_RST;
      end else begin
         s <= next_s;
      end
   end

   assign s_axi_awready_o = !s.aw_got && !s.bvalid;
   assign s_axi_wready_o  = !s.w_got && !s.bvalid;
   assign s_axi_bvalid_o  = s.bvalid;
   assign s_axi_bresp_o   = s.bresp;
   assign s_axi_arready_o = !s.rvalid;
   assign s_axi_rvalid_o  = s.rvalid;
   assign s_axi_rdata_o   = s.rdata;
   assign s_axi_rresp_o   = s.rresp;
   assign sig_wr_o        = s.wr;
   assign cmd_done_o      = s.done;

   signal_store #(
      .NSIG  (NSIG),
      .SIG_W (SIG_W)
   ) u_store (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .wr_en_i   (s.wr.valid),
      .wr_addr_i (s.wr.index[IDX_W-1:0]),
      .wr_data_i (s.wr.value[SIG_W-1:0]),
      .rd_addr_i (s.sig_sel[IDX_W-1:0]),
      .rd_data_o (sel_data)
   );

   name_table #(
      .NAMES (NAMES)
   ) u_names (
      .mclk_i    (mclk_i),
      .sys_rst_i (sys_rst_i),
      .clr_i     (s.nt_clr),
      .wr_en_i   (s.nt_wr),
      .wr_hash_i (s.nt_data[31:16]),
      .wr_idx_i  (s.nt_data[15:0]),
      .key_i     (s.hash),
      .hit_o     (nt_hit),
      .idx_o     (nt_idx)
   );

endmodule

/* File: verif/bulk_signal_write_monitor.sv */
// Concurrent checks on the ports of the bulk signal write handler
`timescale 1ns/10ps
module bulk_signal_write_monitor #(
   parameter int NSIG  = 512,
   parameter int SIG_W = 8
) (
   input wire logic              mclk_i,
   input wire logic              sys_rst_i,
   input wire logic              s_axi_awready_o,
   input wire logic              s_axi_bvalid_o,
   input wire logic              s_axi_bready_i,
   input wire logic              s_axi_arready_o,
   input wire logic              s_axi_rvalid_o,
   input wire logic              s_axi_rready_i,
   input wire logic [1:0]        s_axi_rresp_o,
   input wire bw_pkg::sig_wr_t   sig_wr_o,
   input wire bw_pkg::cmd_done_t cmd_done_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   value_cut_a:
      assert property (sig_wr_o.valid |-> (sig_wr_o.value >> SIG_W) == 32'h0)
         else $error("signal value wider than signal");
   index_range_a:
      assert property (sig_wr_o.valid |-> sig_wr_o.index < NSIG)
         else $error("signal index out of range");
   index_step_a:
      assert property (sig_wr_o.valid && $past(sig_wr_o.valid) && !$past(cmd_done_o.valid)
         |-> sig_wr_o.index == $past(sig_wr_o.index) + 16'h1)
         else $error("back to back writes not consecutive");
   done_pulse_a:
      assert property (cmd_done_o.valid |=> !cmd_done_o.valid)
         else $error("done longer than one cycle");
   bresp_clear_a:
      assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
         else $error("write response not cleared");
   rdata_clear_a:
      assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
         else $error("read response not cleared");
   aw_block_a:
      assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
         else $error("write address taken during response");
   ar_block_a:
      assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
         else $error("read address taken during response");
   cover property (sig_wr_o.valid ##1 sig_wr_o.valid);
   cover property (cmd_done_o.valid && cmd_done_o.err);
   cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h3);
endmodule
bind bulk_signal_write bulk_signal_write_monitor #(.NSIG(NSIG), .SIG_W(SIG_W)) mon_u (.*);

/* File: verif/cmd_host_model.sv */
// Host side that streams command parameter text byte by byte
`timescale 1ns/10ps
module cmd_host_model (
   input  wire logic mclk_i,
   input  wire logic cmd_ready_i,
   output logic [7:0] cmd_byte_o,
   output logic       cmd_valid_o
);
   initial begin
      cmd_byte_o = 8'h00;
      cmd_valid_o = 1'b0;
   end
   // Byte held until taken or for at most 21 edges; idle byte inverted so stale text never looks valid
   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         cmd_valid_o <= 1'b1;
         cmd_byte_o <= s[i];
         // Bounded wait: a stuck handler shows up as missing writes in the bench
         @(posedge mclk_i);
         for (int k = 0; k < 20 && !cmd_ready_i; k++) @(posedge mclk_i);
      end
      cmd_valid_o <= 1'b0;
      cmd_byte_o <= ~cmd_byte_o;
   endtask
endmodule

/* File: verif/bulk_signal_write_bench.sv */
// Self-checking bench for the bulk signal write handler
`timescale 1ns/10ps
`include "bulk_write_defines.svh"
module bulk_signal_write_bench;
   logic mclk_i, sys_rst_i, awv, wv, arv, bry, rry, awr, wr_r, arr, bv, rv, crdy, cv;
   logic [7:0] ad, cb;
   logic [31:0] wd, rd;
   logic [1:0] br, rr;
   bw_pkg::sig_wr_t sw;
   bw_pkg::cmd_done_t cd;
   logic [55:0] wq[$];
   logic [16:0] dq[$];
   int checks = 0, n_errors = 0;
   string s;
   bulk_signal_write dut_u (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .s_axi_awaddr_i(ad),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wr_r), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv),
      .s_axi_bready_i(bry), .s_axi_araddr_i(ad), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .cmd_byte_i(cb), .cmd_valid_i(cv), .cmd_ready_o(crdy), .sig_wr_o(sw), .cmd_done_o(cd));
   cmd_host_model h (.mclk_i(mclk_i), .cmd_ready_i(crdy), .cmd_byte_o(cb), .cmd_valid_o(cv));
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      if (sw.valid === 1'b1) wq.push_back({sw.chan, sw.index, sw.value});
      if (cd.valid === 1'b1) dq.push_back({cd.err, cd.count});
   end
   task automatic chk(input logic ok, input string m);
      checks++;
      if (ok !== 1'b1) begin
         n_errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   // One access at a time; data compared only on an OKAY read
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er, input logic [31:0] ed);
      int k;
      ad <= a;
      wd <= d;
      {awv, wv, arv, bry, rry} <= {w, w, !w, w, !w};
      for (k = 0; k < 40; k++) begin
         @(posedge mclk_i);
         if (awr) awv <= 1'b0;
         if (wr_r) wv <= 1'b0;
         if (arr) arv <= 1'b0;
         if (w ? bv : rv) break;
      end
      {bry, rry} <= 2'b00;
      if (w) chk(k < 40 && br === er, "write response");
      else chk(k < 40 && rr === er && (er !== 2'h0 || rd === ed), "read data");
      // Let an edge pass so the next call never reassigns the ready lines in this step
      @(posedge mclk_i);
   endtask
   task automatic ew(input logic [7:0] c, input logic [15:0] i, input logic [31:0] v);
      chk(wq.size() > 0 && wq.pop_front() === {c, i, v}, "signal write");
   endtask
   task automatic ed(input logic e, input logic [15:0] n);
      for (int k = 0; k < 20 && dq.size() == 0; k++) @(posedge mclk_i);
      chk(dq.size() > 0 && dq.pop_front() === {e, n}, "command done");
   endtask
   task automatic summarize;
      $display("checks %0d n_errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (50000) @(posedge mclk_i);
      n_errors++;
      summarize();
   end
   initial begin
      {awv, wv, arv, bry, rry, ad, wd} = '0;
      sys_rst_i = 1'b1;
      repeat (2) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      axi(0, `BW_REG_CTRL, 0, `BW_RESP_OKAY, 32'h0);
      h.send("0 0 5 7 300\r");
      ed(0, 16'd2);
      ew(0, 5, 7);
      ew(0, 6, 32'h2c);
      axi(0, `BW_REG_STATUS, 0, `BW_RESP_OKAY, 32'h0002_0000);
      axi(1, `BW_REG_SIG_SEL, 6, `BW_RESP_OKAY, 0);
      axi(0, `BW_REG_SIG_DATA, 0, `BW_RESP_OKAY, 32'h2c);
      axi(0, 8'h20, 0, `BW_RESP_DECERR, 0);
      $display("test values done");
      h.send("1 1 10 a\\0Dz\r");
      ed(0, 16'd3);
      ew(1, 10, 32'h61);
      ew(1, 11, 32'h0d);
      ew(1, 12, 32'h7a);
      h.send("2 2 20 3 258\r");
      ed(0, 16'd3);
      for (int i = 20; i < 23; i++) ew(2, i[15:0], 32'h2);
      $display("test string and repeat done");
      axi(1, `BW_REG_CTRL, 32'h0000_0301, `BW_RESP_OKAY, 0);
      h.send("0 30 4\r");
      ed(0, 16'd1);
      ew(3, 30, 4);
      axi(1, `BW_REG_CTRL, 0, `BW_RESP_OKAY, 0);
      axi(1, `BW_REG_NAME, 32'h00a0_0028, `BW_RESP_OKAY, 0);
      h.send("0 0 !ab 9\r");
      ed(0, 16'd1);
      ew(0, 40, 9);
      $display("test socket and name done");
      s = "0 0 0";
      repeat (401) s = {s, " 1"};
      h.send({s, "\r"});
      ed(1, 16'd400);
      chk(wq.size() == 400, "write count");
      wq.delete();
      h.send("0 3 0 1\r");
      ed(1, 16'd0);
      $display("test limits done");
      summarize();
   end
endmodule
